// ### design/hlc_loop_cfg.sv
// Top: loop configuration register and the drive mapping it selects
module hlc_loop_cfg
  import hlc_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_rd,
  output logic      [7:0] o_reg_rdata,
  output logic            o_reg_rvalid,
  input  wire logic       i_closed_loop,
  input  wire logic [7:0] i_level,
  input  wire logic       i_fb_brake_req,
  input  wire logic       i_fb_brake_near_end,
  input  wire logic       i_pwm_cycle_end,
  output logic      [8:0] o_drive,
  output logic            o_brake,
  output logic            o_gain_reduced,
  output logic            o_res_sample,
  output logic            o_bemf_sample,
  output logic            o_decay_active
);
  import hlc_pkg::*;

  // Shared-timer phase: idle, or blanking ahead of a back-EMF conversion
  typedef enum logic [1:0] {
    HLC_PH_SAMPLE = 2'b00,
    HLC_PH_BLANK  = 2'b01
  } hlc_ph_t;

  // decay_pend holds a PWM cycle end that met blanking; kicked, clear after reset, starts the sample timer once
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] rdata;
    logic       rvalid;
    logic [8:0] drive;
    logic       brake;
    logic       gain_red;
    logic       res_smp;
    logic       bemf_smp;
    logic       decay;
    hlc_ph_t    ph;
    logic       decay_pend;
    logic       kicked;
  } hlc_st_t;

  // All state of the block, registered as one word
  hlc_st_t s_reg;
  hlc_st_t s_next;

  // Sample-period timer, and one timer shared by blanking and decay gaps
  hlc_tmr_if smp_t ();
  hlc_tmr_if aux_t ();

  hlc_timer u_smp_timer (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .t         (smp_t.tmr)
  );
  hlc_timer u_aux_timer (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .t         (aux_t.tmr)
  );

  // Field views and level arithmetic
  logic       signed_in;
  logic [1:0] smp_code;
  logic [1:0] blank_code;
  logic [1:0] decay_code;
  logic [8:0] lvl_ext;
  logic [8:0] half_ext;
  logic [8:0] centred;
  logic       below_half;
  logic       aux_busy;
  logic       aux_load_blank;
  logic       aux_load_decay;
  logic       blank_active;
  logic       smp_idle_kick;
  logic [HLC_TW-1:0] blank_load;
  logic [HLC_TW-1:0] decay_load;

  assign signed_in  = s_reg.cfg[HLC_BIT_SIGNED];
  assign smp_code   = s_reg.cfg[HLC_SAMPLE_MSB:HLC_SAMPLE_LSB];
  assign blank_code = s_reg.cfg[HLC_BLANK_MSB:HLC_BLANK_LSB];
  assign decay_code = s_reg.cfg[HLC_DECAY_MSB:HLC_DECAY_LSB];
  assign lvl_ext    = {1'b0, i_level};
  assign half_ext   = {1'b0, HLC_HALF};
  assign centred    = lvl_ext - half_ext;
  assign below_half = i_level < HLC_HALF;

  // Sample period per code; the timer runs load plus one cycles, so load one short
  always_comb begin
    unique case (smp_code)
      2'd0: smp_t.load = HLC_TW'(HLC_SAMPLE_CYC0 - 1);
      2'd1: smp_t.load = HLC_TW'(HLC_SAMPLE_CYC1 - 1);
      2'd2: smp_t.load = HLC_TW'(HLC_SAMPLE_CYC2 - 1);
      2'd3: smp_t.load = HLC_TW'(HLC_SAMPLE_CYC3 - 1);
    endcase
  end

  // Start the sample timer on the first edge after reset, then at every expiry
  assign smp_idle_kick = ~s_reg.kicked;
  assign smp_t.start   = smp_t.done | smp_idle_kick;

  // Blanking delay: one step per code plus one
  always_comb begin
    unique case (blank_code)
      2'd0: blank_load = HLC_TW'(1 * HLC_BLANK_CYC - 1);
      2'd1: blank_load = HLC_TW'(2 * HLC_BLANK_CYC - 1);
      2'd2: blank_load = HLC_TW'(3 * HLC_BLANK_CYC - 1);
      2'd3: blank_load = HLC_TW'(4 * HLC_BLANK_CYC - 1);
    endcase
  end

  // Current-decay gap: one step per code plus one
  always_comb begin
    unique case (decay_code)
      2'd0: decay_load = HLC_TW'(1 * HLC_DECAY_CYC - 1);
      2'd1: decay_load = HLC_TW'(2 * HLC_DECAY_CYC - 1);
      2'd2: decay_load = HLC_TW'(3 * HLC_DECAY_CYC - 1);
      2'd3: decay_load = HLC_TW'(4 * HLC_DECAY_CYC - 1);
    endcase
  end

  // Shared timer: a sample tick always takes it for blanking
  assign blank_active   = s_reg.ph == HLC_PH_BLANK;
  assign aux_load_blank = smp_t.done;
  // A PWM cycle end during blanking is held and served once blanking ends
  assign aux_load_decay = (i_pwm_cycle_end | s_reg.decay_pend) & ~smp_t.done & ~blank_active;
  assign aux_busy       = s_reg.decay | blank_active;
  assign aux_t.start    = aux_load_blank | aux_load_decay;
  assign aux_t.load     = aux_load_blank ? blank_load : decay_load;

  always_comb begin
    s_next          = s_reg;
    s_next.rvalid   = 1'b0;
    s_next.res_smp  = smp_t.done;
    s_next.bemf_smp = 1'b0;
    s_next.kicked   = 1'b1;

    // Register bus: a read in the cycle of a write returns the old value
    if (i_reg_wr && i_reg_addr == HLC_CFG_ADDR) begin
      s_next.cfg = i_reg_wdata;
    end
    if (i_reg_rd) begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = (i_reg_addr == HLC_CFG_ADDR) ? s_reg.cfg : 8'h00;
    end

    // Blanking then back-EMF conversion; decay gap when no blanking pending
    if (aux_load_blank) begin
      s_next.ph    = HLC_PH_BLANK;
      s_next.decay = 1'b0;
    end else if (aux_load_decay) begin
      s_next.decay = 1'b1;
    end else if (aux_t.done && aux_busy) begin
      if (s_reg.ph == HLC_PH_BLANK) begin
        s_next.bemf_smp = 1'b1;
      end
      s_next.ph    = HLC_PH_SAMPLE;
      s_next.decay = 1'b0;
    end

    // A decay request that meets blanking waits here until the timer is free
    if (aux_load_decay) begin
      s_next.decay_pend = 1'b0;
    end else if (i_pwm_cycle_end) begin
      s_next.decay_pend = 1'b1;
    end

    // Drive mapping: signed modes centre on half scale and double the offset; signed closed loop drives zero below half
    if (signed_in) begin
      if (i_closed_loop) begin
        s_next.drive = below_half ? 9'h000 : {centred[7:0], 1'b0};
        s_next.brake = i_fb_brake_req;
      end else begin
        s_next.drive = {centred[7:0], 1'b0};
        s_next.brake = below_half;
      end
    end else begin
      s_next.drive = lvl_ext;
      s_next.brake = i_fb_brake_req;
    end
    s_next.gain_red = s_reg.cfg[HLC_BIT_GAIN_RED] & s_next.brake
                      & i_fb_brake_near_end;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      // Config reloads its power-on value; everything else clears
      s_reg     <= '0;
      s_reg.cfg <= HLC_CFG_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Every output comes straight from the state register
  assign o_reg_rdata    = s_reg.rdata;
  assign o_reg_rvalid   = s_reg.rvalid;
  assign o_drive        = s_reg.drive;
  assign o_brake        = s_reg.brake;
  assign o_gain_reduced = s_reg.gain_red;
  assign o_res_sample   = s_reg.res_smp;
  assign o_bemf_sample  = s_reg.bemf_smp;
  assign o_decay_active = s_reg.decay;
endmodule : hlc_loop_cfg

// ### design/hlc_pkg.sv
// Package: register map, field layout, reset values and timing constants
package hlc_pkg;
  localparam logic [7:0]  HLC_CFG_ADDR      = 8'h1c;
  localparam int          HLC_BIT_SIGNED    = 7;
  localparam int          HLC_BIT_GAIN_RED  = 6;
  localparam int          HLC_SAMPLE_MSB    = 5;
  localparam int          HLC_SAMPLE_LSB    = 4;
  localparam int          HLC_BLANK_MSB     = 3;
  localparam int          HLC_BLANK_LSB     = 2;
  localparam int          HLC_DECAY_MSB     = 1;
  localparam int          HLC_DECAY_LSB     = 0;
  localparam logic [7:0]  HLC_CFG_RESET     = 8'hf5;
  localparam int          HLC_CLK_HZ        = 20_000_000;
  // Sample periods in microseconds per code
  localparam int          HLC_SAMPLE_US0    = 150;
  localparam int          HLC_SAMPLE_US1    = 200;
  localparam int          HLC_SAMPLE_US2    = 250;
  localparam int          HLC_SAMPLE_US3    = 300;
  // Blanking delay and decay gap in nanoseconds, base times code plus one
  localparam int          HLC_BLANK_STEP_NS = 25_000;
  localparam int          HLC_DECAY_STEP_NS = 25_000;
  localparam int          HLC_SAMPLE_CYC0   = HLC_SAMPLE_US0 * (HLC_CLK_HZ / 1_000_000);
  localparam int          HLC_SAMPLE_CYC1   = HLC_SAMPLE_US1 * (HLC_CLK_HZ / 1_000_000);
  localparam int          HLC_SAMPLE_CYC2   = HLC_SAMPLE_US2 * (HLC_CLK_HZ / 1_000_000);
  localparam int          HLC_SAMPLE_CYC3   = HLC_SAMPLE_US3 * (HLC_CLK_HZ / 1_000_000);
  localparam int          HLC_BLANK_CYC     = HLC_BLANK_STEP_NS / (1_000_000_000 / HLC_CLK_HZ);
  localparam int          HLC_DECAY_CYC     = HLC_DECAY_STEP_NS / (1_000_000_000 / HLC_CLK_HZ);
  localparam logic [7:0]  HLC_HALF          = 8'h80;
  localparam int          HLC_TW            = 13;
endpackage : hlc_pkg

// ### design/hlc_timer.sv
// Down counter: loads an interval and pulses done when it runs out
module hlc_timer
  import hlc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  hlc_tmr_if.tmr    t
);
  typedef struct packed {
    logic [HLC_TW-1:0] cnt;
    logic              run;
    logic              done;
  } hlc_tst_t;
  hlc_tst_t s_reg;
  hlc_tst_t s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    if (t.start) begin
      s_next.cnt = t.load;
      s_next.run = 1'b1;
    end else if (s_reg.run) begin
      if (s_reg.cnt <= HLC_TW'(1)) begin
        s_next.run  = 1'b0;
        s_next.done = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt - HLC_TW'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign t.done = s_reg.done;
endmodule : hlc_timer

// ### design/hlc_tmr_if.sv
// Interface: interval timer load and expiry between top and timer
interface hlc_tmr_if;
  logic                         start;
  logic [hlc_pkg::HLC_TW-1:0]   load;
  logic                         done;
  modport ctl (output start, output load, input done);
  modport tmr (input start, input load, output done);
endinterface : hlc_tmr_if

// ### tb/haptic_loop_config_two_bench.sv
// Bench: register access, drive mapping and timer checks for the loop config block
module haptic_loop_config_two_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import hlc_pkg::*;
  logic i_clk = 0, i_sys_rst = 1, i_reg_wr = 0, i_reg_rd = 0, i_closed_loop = 0;
  logic i_fb_brake_req = 0, i_fb_brake_near_end = 0, i_pwm_cycle_end = 0;
  logic [7:0] i_reg_addr = 0, i_reg_wdata = 0, i_level = 0, o_reg_rdata;
  logic o_reg_rvalid, o_brake, o_gain_reduced, o_res_sample, o_bemf_sample, o_decay_active;
  logic [8:0] o_drive;
  logic [7:0] lv [5] = '{8'h00, 8'h40, 8'h80, 8'hc0, 8'hff};
  int bad_count = 0, comparisons = 0, n, m;
  int per [4] = '{HLC_SAMPLE_CYC0, HLC_SAMPLE_CYC1, HLC_SAMPLE_CYC2, HLC_SAMPLE_CYC3};
  always #25 i_clk = ~i_clk;
  hlc_loop_cfg hlc_loop_cfg_i (.i_clk, .i_sys_rst, .i_reg_addr, .i_reg_wr, .i_reg_wdata,
    .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .i_closed_loop, .i_level, .i_fb_brake_req,
    .i_fb_brake_near_end, .i_pwm_cycle_end, .o_drive, .o_brake, .o_gain_reduced,
    .o_res_sample, .o_bemf_sample, .o_decay_active);
  task conclude;
    if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task chk(string nm, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wr(logic [7:0] a, logic [7:0] d);
    @(negedge i_clk);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1;
    @(negedge i_clk);
    i_reg_wr = 0;
  endtask : wr
  task rd(logic [7:0] a, logic [7:0] e);
    @(negedge i_clk);
    i_reg_addr = a;
    i_reg_rd = 1;
    @(negedge i_clk);
    i_reg_rd = 0;
    chk("rvalid", 1, o_reg_rvalid);
    chk("rdata", e, o_reg_rdata);
  endtask : rd
  task drv(logic [7:0] l, logic [8:0] e, logic b);
    @(negedge i_clk);
    i_level = l;
    @(negedge i_clk);
    chk("drive", e, o_drive);
    chk("brake", b, o_brake);
  endtask : drv
  task wait_res;
    n = 0;
    do begin @(negedge i_clk); n++; end while (!o_res_sample && n < 7000);
  endtask : wait_res
  initial begin
    #(90000 * 50);
    bad_count++;
    conclude();
  end
  initial begin
    repeat (4) @(negedge i_clk);
    i_sys_rst = 0;
    rd(8'h1c, 8'hf5);
    rd(8'h1d, 8'h00);
    wr(8'h1d, 8'h3a);
    rd(8'h1c, 8'hf5);
    wr(8'h1c, 8'h3a);
    rd(8'h1c, 8'h3a);
    wr(8'h1c, 8'hf5);
    for (int i = 0; i < 5; i++) drv(lv[i], {lv[i] ^ 8'h80, 1'b0}, lv[i] < 8'h80);
    i_closed_loop = 1;
    for (int i = 0; i < 5; i++) begin
      i_fb_brake_req = i[0];
      drv(lv[i], lv[i] < 8'h80 ? 9'h0 : {lv[i] ^ 8'h80, 1'b0}, i[0]);
    end
    i_fb_brake_req = 1;
    i_fb_brake_near_end = 1;
    repeat (2) @(negedge i_clk);
    chk("gain", 1, o_gain_reduced);
    wr(8'h1c, 8'h35);
    repeat (2) @(negedge i_clk);
    chk("gain", 0, o_gain_reduced);
    for (int i = 0; i < 5; i++) begin
      i_fb_brake_req = i[0];
      i_closed_loop = i[1];
      drv(lv[i], {1'b0, lv[i]}, i[0]);
    end
    for (int k = 0; k < 4; k++) begin
      wr(8'h1c, {2'b10, 2'(k), 2'(k), 2'(k)});
      wait_res();
      wait_res();
      chk("period", 16'(per[k]), 16'(n));
      m = 0;
      do begin @(negedge i_clk); m++; end while (!o_bemf_sample && m < 7000);
      chk("blank", 16'((k + 1) * HLC_BLANK_CYC), 16'(m));
      i_pwm_cycle_end = 1;
      @(negedge i_clk);
      i_pwm_cycle_end = 0;
      m = 0;
      while (o_decay_active && m < 3000) begin @(negedge i_clk); m++; end
      chk("decay", 16'((k + 1) * HLC_DECAY_CYC), 16'(m));
    end
    wait_res();
    i_pwm_cycle_end = 1;
    @(negedge i_clk);
    i_pwm_cycle_end = 0;
    chk("decay held", 0, o_decay_active);
    m = 1;
    while (!o_bemf_sample && m < 7000) begin @(negedge i_clk); m++; end
    chk("blank kept", 16'(4 * HLC_BLANK_CYC), 16'(m));
    @(negedge i_clk);
    chk("decay after blank", 1, o_decay_active);
    i_sys_rst = 1;
    repeat (2) @(negedge i_clk);
    i_sys_rst = 0;
    rd(8'h1c, 8'hf5);
    conclude();
  end
endmodule : haptic_loop_config_two_bench

// ### tb/hlc_loop_cfg_props.sv
// Checker: register bus and drive mapping properties of the loop config block
module hlc_loop_cfg_props (
  input wire logic       i_clk,
  input wire logic       i_sys_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic       i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic       i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       o_reg_rvalid,
  input wire logic       i_closed_loop,
  input wire logic [7:0] i_level,
  input wire logic       i_fb_brake_req,
  input wire logic       i_fb_brake_near_end,
  input wire logic [8:0] o_drive,
  input wire logic       o_brake,
  input wire logic       o_gain_reduced
);
  logic [7:0] cfg_reg;
  // Shadow of the configuration register, mirrors bus writes
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) cfg_reg <= 8'hf5;
    else if (i_reg_wr && i_reg_addr == 8'h1c) cfg_reg <= i_reg_wdata;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  read_valid_a: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read not answered");
  read_cfg_a: assert property (i_reg_rd && i_reg_addr == 8'h1c |=>
    o_reg_rdata == $past(cfg_reg)) else $error("read data wrong");
  read_unmapped_a: assert property (i_reg_rd && i_reg_addr != 8'h1c |=>
    o_reg_rdata == 8'h00) else $error("unmapped read not zero");
  open_brake_a: assert property (cfg_reg[7] && !i_closed_loop |=>
    o_brake == $past(i_level < 8'h80)) else $error("open loop brake wrong");
  open_drive_a: assert property (cfg_reg[7] && !i_closed_loop |=>
    o_drive == {$past(i_level) ^ 8'h80, 1'b0}) else $error("open loop drive wrong");
  closed_low_a: assert property (cfg_reg[7] && i_closed_loop && i_level < 8'h80 |=>
    o_drive == 9'h000) else $error("closed loop low input drives");
  fb_brake_a: assert property (i_closed_loop || !cfg_reg[7] |=>
    o_brake == $past(i_fb_brake_req)) else $error("feedback brake wrong");
  uni_drive_a: assert property (!cfg_reg[7] |=>
    o_drive == {1'b0, $past(i_level)}) else $error("unsigned drive wrong");
  gain_off_a: assert property (!cfg_reg[6] |=> !o_gain_reduced)
    else $error("gain reduced while disabled");
  gain_on_a: assert property (cfg_reg[6] && i_fb_brake_near_end |=>
    o_gain_reduced == o_brake) else $error("gain not reduced near brake end");
endmodule : hlc_loop_cfg_props

bind hlc_loop_cfg hlc_loop_cfg_props hlc_loop_cfg_props_i (.i_clk, .i_sys_rst, .i_reg_addr,
  .i_reg_wr, .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .i_closed_loop,
  .i_level, .i_fb_brake_req, .i_fb_brake_near_end, .o_drive, .o_brake, .o_gain_reduced);
